/* File: hw/twb_slave.sv */
/*
 * two-wire bus slave: 7/10-bit address match, receive byte register,
 * status flags and pin level read-back.
 * assumes external pull-ups (wired-AND bus) and a bus far slower than clk_sys.
 */
`default_nettype none
module twb_slave
    import twb_pkg::*;
(
    // clock and reset
    input  wire logic                clk_sys,
    input  wire logic                rst,
    // configuration
    input  wire logic                enable,
    input  wire logic                ten_bit_mode,
    input  wire logic [9:0]          own_addr,
    // software access
    input  wire logic                status_wr,
    input  wire logic [1:0]          status_be,
    input  wire logic [STATUS_W-1:0] status_wdata,
    output logic      [STATUS_W-1:0] serial_bus_status_register,
    output logic      [7:0]          receive_byte_register,
    input  wire logic                rcv_read,
    input  wire logic [7:0]          tx_byte,
    // pin read-back
    output logic                     scl_level,
    output logic                     sda_level,
    // bus pins
    input  wire logic                serial_clock_pin_i,
    input  wire logic                serial_data_pin_i,
    output logic                     serial_data_pin_o,
    output logic                     serial_data_pin_oe
);
    // ************************************************************
    // pin synchronisation and bus events
    // ************************************************************
    pins_t      raw_pins;
    pins_t      bus;
    pins_t      prev_r;
    bus_state_t state_r;
    bus_state_t state_nxt;
    logic [7:0] sh_r;
    logic [7:0] sh_nxt;
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;
    logic       rw_r;
    logic       rw_nxt;
    logic       hi_match_r;
    logic       hi_nxt;
    logic       rcv_load;
    logic       bus_collision_flag;
    logic       receive_buffer_full_flag;
    logic       acknowledge_status_flag;

    assign raw_pins = '{scl: serial_clock_pin_i, sda: serial_data_pin_i};

    pin_sync3 #(.WIDTH(2)) u_pin_sync3 (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .pin_in    (raw_pins),
        .level_out (bus)
    );

    // read-back is taken straight from the filtered pins, not the fsm
    assign scl_level = bus.scl;
    assign sda_level = bus.sda;

    wire scl_rise  = bus.scl & ~prev_r.scl;
    wire scl_fall  = ~bus.scl & prev_r.scl;
    wire start_det = bus.scl & prev_r.scl & prev_r.sda & ~bus.sda;
    wire stop_det  = bus.scl & prev_r.scl & ~prev_r.sda & bus.sda;
    wire byte_done = scl_fall & (cnt_r == BITS_PER_BYTE);

    // ************************************************************
    // address decode
    // ************************************************************
    // no reserved-address exclusion on the lower byte: every form matches
    wire hi_hit  = (sh_r[7:3] == TEN_BIT_MARK) & (sh_r[2:1] == own_addr[9:8]);
    wire lo_hit  = sh_r == own_addr[7:0];
    wire a7_hit  = sh_r[7:1] == own_addr[6:0];
    wire hi_wr   = ten_bit_mode & hi_hit & ~sh_r[0];
    wire hi_rd   = ten_bit_mode & hi_hit & sh_r[0] & hi_match_r;
    wire hi_ok   = ten_bit_mode ? (hi_wr | hi_rd) : a7_hit;
    wire eval_hi = (state_r == ST_ADDR_HI) & byte_done;
    wire eval_lo = (state_r == ST_ADDR_LO) & byte_done;

    // ************************************************************
    // state and shift control
    // ************************************************************
    always_comb begin
        state_nxt = state_r;
        sh_nxt    = sh_r;
        cnt_nxt   = cnt_r;
        rw_nxt    = rw_r;
        hi_nxt    = hi_match_r;
        rcv_load  = 1'b0;
        case (state_r)
            ST_ADDR_HI, ST_ADDR_LO, ST_RX_DATA: begin
                if (scl_rise) begin
                    sh_nxt  = {sh_r[6:0], bus.sda};
                    cnt_nxt = cnt_r + 4'h1;
                end else if (byte_done) begin
                    state_nxt = ST_WAIT;
                    if (state_r == ST_ADDR_HI && hi_ok) begin
                        state_nxt = ST_ACK_HI;
                        rw_nxt    = sh_r[0];
                        hi_nxt    = ten_bit_mode;
                        rcv_load  = ~ten_bit_mode;
                    end else if (state_r == ST_ADDR_LO && lo_hit) begin
                        state_nxt = ST_ACK_LO;
                        rcv_load  = 1'b1;
                    end else if (state_r == ST_RX_DATA) begin
                        state_nxt = ST_ACK_RX;
                        rcv_load  = 1'b1;
                    end else begin
                        hi_nxt = 1'b0;
                    end
                end
            end
            ST_ACK_HI: begin
                if (scl_fall) begin
                    cnt_nxt = 4'h0;
                    if (rw_r) begin
                        state_nxt = ST_TX_DATA;
                        sh_nxt    = tx_byte;
                    end else begin
                        state_nxt = ten_bit_mode ? ST_ADDR_LO : ST_RX_DATA;
                    end
                end
            end
            ST_ACK_LO, ST_ACK_RX: begin
                if (scl_fall) begin
                    state_nxt = ST_RX_DATA;
                    cnt_nxt   = 4'h0;
                end
            end
            ST_TX_DATA: begin
                if (scl_rise) begin
                    cnt_nxt = cnt_r + 4'h1;
                    if (sh_r[7] & ~bus.sda) begin
                        state_nxt = ST_WAIT;
                    end
                end else if (byte_done) begin
                    state_nxt = ST_ACK_TX;
                end else if (scl_fall) begin
                    sh_nxt = {sh_r[6:0], 1'b0};
                end
            end
            ST_ACK_TX: begin
                // a not-acknowledge ends the read; an acknowledge loads the next byte
                if (scl_rise && bus.sda) begin
                    state_nxt = ST_WAIT;
                end else if (scl_fall) begin
                    state_nxt = ST_TX_DATA;
                    sh_nxt    = tx_byte;
                    cnt_nxt   = 4'h0;
                end
            end
            ST_IDLE, ST_WAIT: begin
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
        // start and stop override any byte in progress
        if (start_det) begin
            state_nxt = ST_ADDR_HI;
            cnt_nxt   = 4'h0;
        end else if (stop_det) begin
            state_nxt = ST_IDLE;
            hi_nxt    = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst || !enable) begin
            state_r    <= ST_IDLE;
            sh_r       <= 8'h00;
            cnt_r      <= 4'h0;
            rw_r       <= 1'b0;
            hi_match_r <= 1'b0;
            prev_r     <= '{scl: 1'b1, sda: 1'b1};
        end else begin
            state_r    <= state_nxt;
            sh_r       <= sh_nxt;
            cnt_r      <= cnt_nxt;
            rw_r       <= rw_nxt;
            hi_match_r <= hi_nxt;
            prev_r     <= bus;
        end
    end

    // ************************************************************
    // status flags and receive register
    // ************************************************************
    // set beats clear on every flag so a same-cycle event is never lost
    wire collide   = (state_r == ST_TX_DATA) & scl_rise & sh_r[7] & ~bus.sda;
    wire coll_clr  = status_wr & (status_be == FULL_WORD_BE) & ~status_wdata[COLLISION_POS];
    wire ack_smp   = (state_r == ST_ACK_TX) & scl_rise;
    wire nack_seen = ack_smp & bus.sda;
    wire ack_seen  = ack_smp & ~bus.sda;

    // start and stop do not touch acknowledge status, only the next ack bit does
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            bus_collision_flag       <= 1'b0;
            receive_buffer_full_flag <= 1'b0;
            acknowledge_status_flag  <= 1'b0;
            receive_byte_register    <= RCV_RESET;
        end else begin
            bus_collision_flag       <= collide | (bus_collision_flag & ~coll_clr);
            receive_buffer_full_flag <= rcv_load | (receive_buffer_full_flag & ~rcv_read);
            acknowledge_status_flag  <= nack_seen | (acknowledge_status_flag & ~ack_seen);
            if (rcv_load) begin
                receive_byte_register <= sh_r;
            end
        end
    end

    always_comb begin
        serial_bus_status_register              = '0;
        serial_bus_status_register[ACK_STATUS_POS] = acknowledge_status_flag;
        serial_bus_status_register[COLLISION_POS]  = bus_collision_flag;
        serial_bus_status_register[RX_FULL_POS]    = receive_buffer_full_flag;
    end

    // open drain: only ever pull low, released one reads through the bus
    wire ack_drive = (state_r == ST_ACK_HI) | (state_r == ST_ACK_LO) | (state_r == ST_ACK_RX);
    assign serial_data_pin_o  = 1'b0;
    assign serial_data_pin_oe = ack_drive | ((state_r == ST_TX_DATA) & ~sh_r[7]);

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    coll_word_clear_a: assert property (coll_clr && !collide |=> !bus_collision_flag)
        else $error("collision flag survived a full-word clear");
    coll_byte_keep_a: assert property (status_wr && status_be != FULL_WORD_BE && bus_collision_flag
        |=> bus_collision_flag)
        else $error("collision flag lost on partial write");
    wired_and_a: assert property (state_r == ST_TX_DATA && scl_rise && sh_r[7] && !bus.sda
        |=> bus_collision_flag && state_r != ST_TX_DATA)
        else $error("released bit seen low not flagged");
    // expected byte is the own address, not the shifter, so a corrupted load is caught
    lo_byte_exact_a: assert property (eval_lo && lo_hit && !start_det && !stop_det
        |=> receive_byte_register == $past(own_addr[7:0]))
        else $error("lower address byte altered");
    ack_both_a: assert property (eval_hi && hi_ok && !start_det && !stop_det
        |=> serial_data_pin_oe && state_r == ST_ACK_HI)
        else $error("upper address byte not acknowledged");
    ack_lo_a: assert property (eval_lo && lo_hit && !start_det && !stop_det
        |=> serial_data_pin_oe && state_r == ST_ACK_LO)
        else $error("lower address byte not acknowledged");
    pin_follow_a: assert property ($stable(serial_data_pin_i) [*4] ##1 $stable(serial_data_pin_i)
        |-> sda_level == serial_data_pin_i)
        else $error("data level read-back does not follow pin");
    // reserved forms sit in address bits 7..4 of the lower byte
    reserved_match_a: assert property (eval_lo && lo_hit && !start_det && !stop_det
        && (own_addr[7:4] == 4'h0 || own_addr[7:4] == 4'hF) |=> receive_buffer_full_flag)
        else $error("reserved-form lower byte not flagged");
    // exception forms: lower byte looks like a header carrying the same top two bits
    except_match_a: assert property (eval_lo && lo_hit && own_addr[7:3] == TEN_BIT_MARK
        && own_addr[2:1] == own_addr[9:8] && !start_det && !stop_det
        |=> receive_buffer_full_flag && receive_byte_register == $past(own_addr[7:0]))
        else $error("exception-form address not matched");
    nack_sticky_a: assert property (acknowledge_status_flag && !ack_seen |=> acknowledge_status_flag)
        else $error("acknowledge status cleared without an ack bit");
    nack_set_a: assert property (nack_seen |=> acknowledge_status_flag)
        else $error("not-acknowledge did not set status");

    ten_bit_write_c: cover property (eval_lo && lo_hit ##[1:1000] state_r == ST_ACK_RX);
    read_byte_c: cover property (state_r == ST_TX_DATA ##[1:1000] ack_seen);
    collision_c: cover property (collide);
    nack_c: cover property (nack_seen ##[1:1000] start_det);
endmodule // twb_slave
`default_nettype wire

/* File: hw/twb_pkg.sv */
/*
 * shared constants and types for the two-wire bus slave block.
 * assumes a single 10 MHz system clock and a synchronous active-high reset.
 */
`default_nettype none
package twb_pkg;
    // ************************************************************
    // status word layout and reset values
    // ************************************************************
    localparam int          STATUS_W     = 16;
    localparam int          ACK_STATUS_POS = 15;
    localparam int          COLLISION_POS  = 10;
    localparam int          RX_FULL_POS    = 1;
    localparam logic [1:0]  FULL_WORD_BE = 2'h3;
    localparam logic [7:0]  RCV_RESET    = 8'h00;
    localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
    // first byte of a 10-bit address carries this marker in its top five bits
    localparam logic [4:0]  TEN_BIT_MARK = 5'h1E;

    // ************************************************************
    // types
    // ************************************************************
    typedef struct packed {
        logic scl;
        logic sda;
    } pins_t;

    typedef enum logic [9:0] {
        ST_IDLE    = 10'h001,
        ST_ADDR_HI = 10'h002,
        ST_ACK_HI  = 10'h004,
        ST_ADDR_LO = 10'h008,
        ST_ACK_LO  = 10'h010,
        ST_RX_DATA = 10'h020,
        ST_ACK_RX  = 10'h040,
        ST_TX_DATA = 10'h080,
        ST_ACK_TX  = 10'h100,
        ST_WAIT    = 10'h200
    } bus_state_t;
endpackage
`default_nettype wire

/* File: hw/pin_sync3.sv */
/*
 * three-stage pin synchroniser with agreement filter.
 * assumes inputs are asynchronous to clk_sys; output moves only when
 * stages two and three agree.
 */
`default_nettype none
module pin_sync3 #(
    parameter int WIDTH = 2
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst,
    // raw and filtered levels
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] level_out
);
    logic [WIDTH-1:0] st1_r;
    logic [WIDTH-1:0] st2_r;
    logic [WIDTH-1:0] st3_r;
    logic [WIDTH-1:0] agree;
    logic [WIDTH-1:0] level_nxt;

    // stage one is read only by stage two
    assign agree     = ~(st2_r ^ st3_r);
    assign level_nxt = (agree & st3_r) | (~agree & level_out);

    // idle bus is high, so reset to ones
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st1_r     <= '1;
            st2_r     <= '1;
            st3_r     <= '1;
            level_out <= '1;
        end else begin
            st1_r     <= pin_in;
            st2_r     <= st1_r;
            st3_r     <= st2_r;
            level_out <= level_nxt;
        end
    end
endmodule // pin_sync3
`default_nettype wire

/* File: tb/twb_bus_master_model.sv */
/*
 * behavioural two-wire bus master that sits across the bus from the slave.
 * assumes the bench resolves the wired-and sda line and drives scl from here only.
 */
`default_nettype none
module twb_bus_master_model (
    // clock
    input  wire logic clk_sys,
    // bus
    input  wire logic sda_bus,
    output logic      scl_drv,
    output logic      sda_drv
);
    timeunit 1ns;
    timeprecision 1ns;
    // ************************************************************
    // bus phases
    // ************************************************************
    // eight cycles a phase leaves room for the slave's pin filter
    localparam int PH = 8;

    initial begin
        scl_drv = 1'b1;
        sda_drv = 1'b1;
    end

    // set both lines, then hold one phase
    task automatic step(input logic c, input logic d);
        scl_drv = c;
        sda_drv = d;
        repeat (PH) @(negedge clk_sys);
    endtask

    task automatic start();
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
    endtask

    task automatic rstart();
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
    endtask

    task automatic stop();
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
    endtask

    // data changes only while scl is low, msb first
    task automatic send(input logic [7:0] b, output logic ak);
        for (int i = 7; i >= 0; i--) begin
            step(1'b0, b[i]);
            step(1'b1, b[i]);
            step(1'b0, b[i]);
        end
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        ak = ~sda_bus;
        step(1'b0, 1'b1);
    endtask

    // low=1 pulls sda down under the slave's bits to force a collision
    task automatic recv(input logic mack, input logic low, output logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            step(1'b0, ~low);
            step(1'b1, ~low);
            b[i] = sda_bus;
            step(1'b0, ~low);
        end
        step(1'b0, ~mack);
        step(1'b1, ~mack);
        step(1'b0, ~mack);
    endtask
endmodule // twb_bus_master_model
`default_nettype wire

/* File: tb/twb_slave_tb_top.sv */
/*
 * self-checking bench for the two-wire bus slave.
 * assumes the design package and the bus master model are compiled first.
 */
`default_nettype none
module twb_slave_tb_top
    import twb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // ************************************************************
    // stimulus, wiring and checks
    // ************************************************************
    logic                clk_sys = 1'b0;
    logic                rst     = 1'b1;
    logic                enable  = 1'b0;
    logic                ten_bit_mode = 1'b1;
    logic                status_wr = 1'b0;
    logic                rcv_read  = 1'b0;
    logic [9:0]          own_addr  = 10'h002;
    logic [1:0]          status_be = 2'h0;
    logic [STATUS_W-1:0] status_wdata = 16'h0000;
    logic [STATUS_W-1:0] status_q;
    logic [7:0]          rcv_q;
    logic [7:0]          tx_byte = 8'hA5;
    logic [7:0]          rb;
    logic                scl_level, sda_level, sda_o, sda_oe, scl_drv, sda_drv, ak;
    logic [9:0]          tbl [7] = '{10'h002, 10'h105, 10'h2F3, 10'h0F1, 10'h1F2, 10'h2F5, 10'h3F6};
    logic [1:0]          pins [4] = '{2'b01, 2'b00, 2'b10, 2'b11};
    int                  err_count = 0;
    int                  checked   = 0;
    // pull-up plus open-drain pulls: the wire is the and of all drivers
    wire logic           sda_bus = sda_drv & ~(sda_oe & ~sda_o);

    always #50 clk_sys = ~clk_sys;

    twb_slave u_twb_slave (
        .clk_sys(clk_sys), .rst(rst), .enable(enable), .ten_bit_mode(ten_bit_mode), .own_addr(own_addr),
        .status_wr(status_wr), .status_be(status_be), .status_wdata(status_wdata),
        .serial_bus_status_register(status_q), .receive_byte_register(rcv_q), .rcv_read(rcv_read),
        .tx_byte(tx_byte), .scl_level(scl_level), .sda_level(sda_level),
        .serial_clock_pin_i(scl_drv), .serial_data_pin_i(sda_bus),
        .serial_data_pin_o(sda_o), .serial_data_pin_oe(sda_oe));

    twb_bus_master_model u_twb_bus_master_model (
        .clk_sys(clk_sys), .sda_bus(sda_bus), .scl_drv(scl_drv), .sda_drv(sda_drv));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // one-cycle software pulses, launched off the falling edge
    task automatic pulse_sw(input logic wr, input logic [1:0] be);
        @(negedge clk_sys);
        status_wr = wr;
        rcv_read  = ~wr;
        status_be = be;
        @(negedge clk_sys);
        status_wr = 1'b0;
        rcv_read  = 1'b0;
    endtask

    // start plus both 10-bit address bytes, write direction
    task automatic addr10(input logic [9:0] a, input logic exp_ack);
        u_twb_bus_master_model.start();
        u_twb_bus_master_model.send({TEN_BIT_MARK, a[9:8], 1'b0}, ak);
        chk(ak, exp_ack, "upper address ack");
        u_twb_bus_master_model.send(a[7:0], ak);
        chk(ak, exp_ack, "lower address ack");
    endtask

    // read header after a repeated start, then one byte back
    task automatic read10(input logic mack, input logic low);
        addr10(own_addr, 1'b1);
        u_twb_bus_master_model.rstart();
        u_twb_bus_master_model.send({TEN_BIT_MARK, own_addr[9:8], 1'b1}, ak);
        chk(ak, 1'b1, "read header ack");
        u_twb_bus_master_model.recv(mack, low, rb);
    endtask

    initial begin
        repeat (10) @(negedge clk_sys);
        rst = 1'b0;
        enable = 1'b1;
        repeat (4) @(negedge clk_sys);
        chk(status_q, 16'h0000, "status after reset");
        chk(rcv_q, 8'h00, "receive byte after reset");
        // pin read-back while enabled
        foreach (pins[i]) begin
            u_twb_bus_master_model.step(pins[i][1], pins[i][0]);
            chk({scl_level, sda_level}, pins[i], "pin read-back");
        end
        // lower byte loads exactly, reserved-looking forms included
        foreach (tbl[i]) begin
            own_addr = tbl[i];
            addr10(tbl[i], 1'b1);
            u_twb_bus_master_model.stop();
            chk(rcv_q, tbl[i][7:0], "lower address byte");
            chk(status_q[RX_FULL_POS], 1'b1, "receive full set");
            pulse_sw(1'b0, 2'h0);
            chk(status_q[RX_FULL_POS], 1'b0, "receive full cleared");
        end
        // 7-bit mode: the address byte itself lands in the receive register
        ten_bit_mode = 1'b0;
        own_addr     = 10'h055;
        u_twb_bus_master_model.start();
        u_twb_bus_master_model.send({own_addr[6:0], 1'b0}, ak);
        chk(ak, 1'b1, "7-bit address ack");
        u_twb_bus_master_model.stop();
        chk(rcv_q, 8'hAA, "7-bit address byte");
        chk(status_q[RX_FULL_POS], 1'b1, "7-bit receive full");
        ten_bit_mode = 1'b1;
        // foreign address with other top bits is ignored
        own_addr = 10'h102;
        addr10(10'h202, 1'b0);
        u_twb_bus_master_model.stop();
        // not-acknowledge survives later start and stop
        read10(1'b0, 1'b0);
        chk(rb, tx_byte, "read byte");
        chk(status_q[ACK_STATUS_POS], 1'b1, "nack sets ack status");
        u_twb_bus_master_model.stop();
        u_twb_bus_master_model.start();
        u_twb_bus_master_model.stop();
        chk(status_q[ACK_STATUS_POS], 1'b1, "ack status kept");
        // collision, then partial writes must not clear it
        read10(1'b1, 1'b1);
        u_twb_bus_master_model.stop();
        chk(status_q[COLLISION_POS], 1'b1, "collision seen");
        pulse_sw(1'b1, 2'h1);
        chk(status_q[COLLISION_POS], 1'b1, "byte write keeps collision");
        pulse_sw(1'b1, 2'h2);
        chk(status_q[COLLISION_POS], 1'b1, "byte write keeps collision");
        pulse_sw(1'b1, FULL_WORD_BE);
        chk(status_q[COLLISION_POS], 1'b0, "word write clears collision");
        final_report();
    end

    // watchdog: the run needs some 6100 cycles
    initial begin
        repeat (40000) @(posedge clk_sys);
        err_count++;
        $display("mismatch at %0t: watchdog expired", $time);
        final_report();
    end
endmodule // twb_slave_tb_top
`default_nettype wire
